// file: meter_chain_pkg.sv
// shared constants and types for the meter sample processing chain
package meter_chain_pkg;

   // data widths
   localparam int SAMPLE_W = 24;
   localparam int ADDR_W   = 8;
   localparam int DATA_W   = 32;
   localparam int VAL_W    = 32;
   localparam int SUM_W    = 38;
   localparam int CNT_W    = 14;
   localparam int DIV_W    = 48;
   localparam int DEN_W    = 32;
   localparam int COEF_W   = 16;
   localparam int TBL_N    = 16;
   localparam int HIST_DEPTH = 10000;

   // averaging lengths
   localparam logic [CNT_W-1:0] NAVG_10    = 14'h000a;
   localparam logic [CNT_W-1:0] NAVG_100   = 14'h0064;
   localparam logic [CNT_W-1:0] NAVG_1000  = 14'h03e8;
   localparam logic [CNT_W-1:0] NAVG_10000 = 14'h2710;

   // register offsets
   localparam logic [ADDR_W-1:0] CTRL_OFS      = 8'h00;
   localparam logic [ADDR_W-1:0] ZERO_OFS      = 8'h04;
   localparam logic [ADDR_W-1:0] CMD_OFS       = 8'h08;
   localparam logic [ADDR_W-1:0] USER_RESP_OFS = 8'h0c;
   localparam logic [ADDR_W-1:0] AREA_OFS      = 8'h10;
   localparam logic [ADDR_W-1:0] WAVE_OFS      = 8'h14;
   localparam logic [ADDR_W-1:0] STATUS_OFS    = 8'h18;
   localparam logic [ADDR_W-1:0] RESULT_OFS    = 8'h1c;
   localparam logic [1:0]        GAIN_PAGE     = 2'h0;
   localparam logic [1:0]        RESP_OFF_PAGE = 2'h1;
   localparam logic [1:0]        RESP_ON_PAGE  = 2'h2;
   localparam logic [1:0]        GAIN_SUBPAGE  = 2'h2;

   // control register fields
   localparam int CTRL_W       = 13;
   localparam int AVG_EN_BIT   = 0;
   localparam int NSEL_LSB     = 1;
   localparam int ZERO_EN_BIT  = 3;
   localparam int ATTEN_BIT    = 4;
   localparam int UNITS_LSB    = 5;
   localparam int RANGE_LSB    = 8;
   localparam int MODE_LSB     = 10;
   localparam int USER_CAL_BIT = 12;
   localparam int CAPTURE_BIT  = 0;
   localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;

   // display units and operating modes
   localparam logic [2:0] UNITS_AMPS  = 3'h0;
   localparam logic [2:0] UNITS_WATTS = 3'h2;
   localparam logic [2:0] UNITS_WCM2  = 3'h3;
   localparam logic [2:0] UNITS_DBM   = 3'h6;
   localparam logic [1:0] MODE_CW_CONT = 2'h0;
   localparam logic [1:0] MODE_SINGLE  = 2'h1;
   localparam logic [1:0] MODE_PEAK    = 2'h2;

   // fixed-point scaling and reset values
   localparam int GAIN_FRAC = 8;
   localparam int RESP_FRAC = 12;
   localparam int AREA_FRAC = 8;
   localparam logic [COEF_W-1:0] GAIN_RST = 16'h0100;
   localparam logic [COEF_W-1:0] RESP_RST = 16'h1000;
   localparam logic [COEF_W-1:0] AREA_RST = 16'h0100;
   localparam logic [VAL_W-1:0]  ZERO_RST = 32'h0000_0000;
   localparam logic [5:0]        DIV_STEPS = 6'h30;

   // processing sequencer, gray coded along the path
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_READ = 4'h1,
      ST_ACC  = 4'h3,
      ST_DIVM = 4'h2,
      ST_GAIN = 4'h6,
      ST_ZERO = 4'h7,
      ST_DIVR = 4'h5,
      ST_DIVA = 4'h4,
      ST_PUSH = 4'hc,
      ST_PEAK = 4'hd
   } chain_state_e;

endpackage

// file: result_skid_buffer.sv
// two-entry result buffer with valid/ready on both sides
`timescale 1ns/1ps
module result_skid_buffer
   import meter_chain_pkg::*;
#(
   parameter int W = 32
)
(
   input  wire logic         sys_clk,
   input  wire logic         sys_rst,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);

   typedef struct packed {
      logic         v0;
      logic         v1;
      logic [W-1:0] d0;
      logic [W-1:0] d1;
   } skid_s;

   skid_s r_r;
   skid_s r_nxt;

   // head entry feeds the output, second entry absorbs a stall
   always_comb
   begin
      logic push;
      logic pop;
      push  = 1'b0;
      pop   = 1'b0;
      r_nxt = r_r;
      push  = in_valid & ~r_r.v1;
      pop   = r_r.v0 & out_ready;
      if (pop)
      begin
         if (r_r.v1)
         begin
            r_nxt.d0 = r_r.d1;
            r_nxt.v1 = push;
            r_nxt.d1 = in_data;
         end
         else
         begin
            r_nxt.v0 = push;
            r_nxt.d0 = in_data;
         end
      end
      else if (push)
      begin
         if (!r_r.v0)
         begin
            r_nxt.v0 = 1'b1;
            r_nxt.d0 = in_data;
         end
         else
         begin
            r_nxt.v1 = 1'b1;
            r_nxt.d1 = in_data;
         end
      end
   end

   // state register
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         r_r <= '0;
      else
         r_r <= r_nxt;
   end

   assign in_ready  = ~r_r.v1;
   assign out_valid = r_r.v0;
   assign out_data  = r_r.d0;

endmodule

// file: meter_sample_chain.sv
// sample processing chain: averaging, gain, zero, responsivity, units
`timescale 1ns/1ps
// Notes on behaviour
// (R1) with averaging on, output the mean of the last N of 10/100/1000/10000
// (R2) before N samples since clearing, output the mean of all samples so far
// (R3) clear the filter at reset and on units, range or mode change
// (R4) single acquisition averaging ignores sample age; no time expiry
// (R5) multiply each value by the gain of the selected input range
// (R6) zero offset enabled subtracts stored reference, else value passes
// (R7) divide by responsivity of wavelength map or user calibration value
// (R8) responsivity table chosen by attenuator on or off
// (R9) display units equal to detector units leave the value unadjusted
// (R10) per-area units divide the value by detector active area
// (R11) peak-to-peak mode tracks maximum and minimum, reports difference
// (R12) zero reference loaded directly or captured from present reading
// (R13) order: filter, gain, zero, responsivity, units; one result per sample
module meter_sample_chain
   import meter_chain_pkg::*;
(
   input  wire logic                sys_clk,
   input  wire logic                sys_rst,
   input  wire logic [ADDR_W-1:0]   reg_addr,
   input  wire logic [DATA_W-1:0]   reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic [DATA_W-1:0]        reg_rdata,
   input  wire logic                smp_valid,
   input  wire logic [SAMPLE_W-1:0] smp_data,
   output logic                     smp_ready,
   output logic                     res_valid,
   output logic [VAL_W-1:0]         res_data,
   input  wire logic                res_ready
);

   typedef struct packed {
      chain_state_e                  st;
      logic                          in_rdy;
      logic [CTRL_W-1:0]             ctrl;
      logic [VAL_W-1:0]              zero_ref;
      logic [VAL_W-1:0]              pre_zero;
      logic [VAL_W-1:0]              val;
      logic [VAL_W-1:0]              last;
      logic [COEF_W-1:0]             user_resp;
      logic [COEF_W-1:0]             area;
      logic [3:0]                    wave;
      logic [3:0][COEF_W-1:0]        gain;
      logic [TBL_N-1:0][COEF_W-1:0]  resp_off;
      logic [TBL_N-1:0][COEF_W-1:0]  resp_on;
      logic [SUM_W-1:0]              sum;
      logic [CNT_W-1:0]              cnt;
      logic [CNT_W-1:0]              ptr;
      logic [SAMPLE_W-1:0]           smp;
      logic [SAMPLE_W-1:0]           pk_max;
      logic [SAMPLE_W-1:0]           pk_min;
      logic                          pk_ok;
      logic [DIV_W-1:0]              dq;
      logic [DEN_W:0]                drem;
      logic [DEN_W-1:0]              dden;
      logic [5:0]                    dcnt;
      logic                          dneg;
      logic [DATA_W-1:0]             rdata;
   } chain_s;

   chain_s r_r;
   chain_s r_nxt;

   logic [SAMPLE_W-1:0] hist [0:HIST_DEPTH-1];
   logic [SAMPLE_W-1:0] hist_old_r;
   logic                buf_ready;

   // averaging length from the selector field
   function automatic logic [CNT_W-1:0] navg_of(input logic [1:0] sel);
      logic [CNT_W-1:0] n;
      unique case (sel)
         2'h0: n = NAVG_10;
         2'h1: n = NAVG_100;
         2'h2: n = NAVG_1000;
         2'h3: n = NAVG_10000;
      endcase
      return n;
   endfunction

   // table page of an address: 0 none, 1 resp off, 2 resp on, 3 gain
   function automatic logic [1:0] page_of(input logic [ADDR_W-1:0] a);
      logic [1:0] p;
      p = 2'h0;
      if (a[7:6] == RESP_OFF_PAGE)
         p = 2'h1;
      else if (a[7:6] == RESP_ON_PAGE)
         p = 2'h2;
      else if (a[7:6] == GAIN_PAGE && a[5:4] == GAIN_SUBPAGE)
         p = 2'h3;
      return p;
   endfunction

   // start a signed-by-unsigned long division
   function automatic chain_s div_start(input chain_s s,
                                        input logic [DIV_W-1:0] num,
                                        input logic [DEN_W-1:0] den);
      chain_s o;
      o      = s;
      o.dneg = num[DIV_W-1];
      o.dq   = num[DIV_W-1] ? (~num + 48'h1) : num;
      o.drem = '0;
      o.dden = (den == '0) ? 32'h0000_0001 : den;
      o.dcnt = DIV_STEPS;
      return o;
   endfunction

   // signed quotient of the finished division
   function automatic logic [VAL_W-1:0] div_result(input chain_s s);
      logic [DIV_W-1:0] q;
      q = s.dneg ? (~s.dq + 48'h1) : s.dq;
      return q[VAL_W-1:0];
   endfunction

   // registers, sequencer and arithmetic
   always_comb
   begin
      logic [DEN_W:0]         t;
      logic [CNT_W-1:0]       nsel;
      logic                   clr;
      logic                   full;
      logic [SUM_W-1:0]       s_new;
      logic signed [48:0]     prod;
      logic [COEF_W-1:0]      resp;
      logic [2:0]             units;
      logic [CTRL_W-1:0]      wc;
      t     = '0;
      resp  = '0;
      clr   = 1'b0;
      full  = 1'b0;
      s_new = '0;
      prod  = '0;
      wc    = reg_wdata[CTRL_W-1:0];
      r_nxt = r_r;
      r_nxt.rdata = '0;
      nsel  = navg_of(r_r.ctrl[NSEL_LSB +: 2]);
      units = r_r.ctrl[UNITS_LSB +: 3];

      // register writes
      if (reg_wr)
      begin
         unique case (reg_addr)
            CTRL_OFS:
            begin
               if (wc[UNITS_LSB +: 3] != units
                   || wc[RANGE_LSB +: 2] != r_r.ctrl[RANGE_LSB +: 2]
                   || wc[MODE_LSB +: 2] != r_r.ctrl[MODE_LSB +: 2]
                   || wc[NSEL_LSB +: 2] != r_r.ctrl[NSEL_LSB +: 2])
                  clr = 1'b1; // R3
               r_nxt.ctrl = wc;
            end
            ZERO_OFS:      r_nxt.zero_ref = reg_wdata; // R12
            CMD_OFS:
            begin
               if (reg_wdata[CAPTURE_BIT])
                  r_nxt.zero_ref = r_r.pre_zero; // R12
            end
            USER_RESP_OFS: r_nxt.user_resp = reg_wdata[COEF_W-1:0];
            AREA_OFS:      r_nxt.area = reg_wdata[COEF_W-1:0];
            WAVE_OFS:      r_nxt.wave = reg_wdata[3:0];
            default:
            begin
               unique case (page_of(reg_addr))
                  2'h1: r_nxt.resp_off[reg_addr[5:2]] = reg_wdata[COEF_W-1:0];
                  2'h2: r_nxt.resp_on[reg_addr[5:2]] = reg_wdata[COEF_W-1:0];
                  2'h3: r_nxt.gain[reg_addr[3:2]] = reg_wdata[COEF_W-1:0];
                  default: r_nxt.rdata = '0;
               endcase
            end
         endcase
      end

      // register reads, data stands one cycle
      if (reg_rd)
      begin
         unique case (reg_addr)
            CTRL_OFS:      r_nxt.rdata = {19'h0, r_r.ctrl};
            ZERO_OFS:      r_nxt.rdata = r_r.zero_ref;
            USER_RESP_OFS: r_nxt.rdata = {16'h0, r_r.user_resp};
            AREA_OFS:      r_nxt.rdata = {16'h0, r_r.area};
            WAVE_OFS:      r_nxt.rdata = {28'h0, r_r.wave};
            STATUS_OFS:    r_nxt.rdata = {12'h0, r_r.st, 2'h0, r_r.cnt};
            RESULT_OFS:    r_nxt.rdata = r_r.last;
            default:
            begin
               unique case (page_of(reg_addr))
                  2'h1: r_nxt.rdata = {16'h0, r_r.resp_off[reg_addr[5:2]]};
                  2'h2: r_nxt.rdata = {16'h0, r_r.resp_on[reg_addr[5:2]]};
                  2'h3: r_nxt.rdata = {16'h0, r_r.gain[reg_addr[3:2]]};
                  default: r_nxt.rdata = '0;
               endcase
            end
         endcase
      end

      // one long division step per cycle
      if (r_r.dcnt != 6'h0)
      begin
         t = {r_r.drem[DEN_W-1:0], r_r.dq[DIV_W-1]};
         if (t >= {1'b0, r_r.dden})
         begin
            r_nxt.drem = t - {1'b0, r_r.dden};
            r_nxt.dq   = {r_r.dq[DIV_W-2:0], 1'b1};
         end
         else
         begin
            r_nxt.drem = t;
            r_nxt.dq   = {r_r.dq[DIV_W-2:0], 1'b0};
         end
         r_nxt.dcnt = r_r.dcnt - 6'h1;
      end

      // resp table by attenuator, user value overrides
      if (r_r.ctrl[USER_CAL_BIT])
         resp = r_r.user_resp; // R7
      else if (r_r.ctrl[ATTEN_BIT])
         resp = r_r.resp_on[r_r.wave]; // R8
      else
         resp = r_r.resp_off[r_r.wave]; // R8

      // processing sequence, one result per accepted sample
      unique case (r_r.st)
         ST_IDLE:
         begin
            if (r_r.in_rdy && smp_valid)
            begin
               r_nxt.smp = smp_data;
               if (r_r.ctrl[MODE_LSB +: 2] == MODE_PEAK)
                  r_nxt.st = ST_PEAK; // R11
               else if (r_r.ctrl[AVG_EN_BIT])
                  r_nxt.st = ST_READ; // R13
               else
               begin
                  r_nxt.val = {{(VAL_W-SAMPLE_W){smp_data[SAMPLE_W-1]}}, smp_data};
                  r_nxt.st  = ST_GAIN;
               end
            end
         end
         ST_READ: r_nxt.st = ST_ACC;
         ST_ACC:
         begin
            // oldest word leaves only once N are held, whatever its age
            full  = (r_r.cnt == nsel); // R4
            s_new = r_r.sum + {{(SUM_W-SAMPLE_W){r_r.smp[SAMPLE_W-1]}}, r_r.smp};
            if (full)
               s_new = s_new - {{(SUM_W-SAMPLE_W){hist_old_r[SAMPLE_W-1]}}, hist_old_r}; // R1
            else
               r_nxt.cnt = r_r.cnt + 14'h1; // R2
            r_nxt.sum = s_new;
            r_nxt.ptr = (r_r.ptr == nsel - 14'h1) ? '0 : r_r.ptr + 14'h1;
            r_nxt = div_start(r_nxt, {{(DIV_W-SUM_W){s_new[SUM_W-1]}}, s_new},
                              {18'h0, r_nxt.cnt}); // R2
            r_nxt.st = ST_DIVM;
         end
         ST_DIVM:
         begin
            if (r_r.dcnt == 6'h0)
            begin
               r_nxt.val = div_result(r_r); // R1
               r_nxt.st  = ST_GAIN;
            end
         end
         ST_PEAK:
         begin
            if (!r_r.pk_ok || $signed(r_r.smp) > $signed(r_r.pk_max))
               r_nxt.pk_max = r_r.smp; // R11
            if (!r_r.pk_ok || $signed(r_r.smp) < $signed(r_r.pk_min))
               r_nxt.pk_min = r_r.smp; // R11
            r_nxt.pk_ok = 1'b1;
            r_nxt.val = {{(VAL_W-SAMPLE_W){1'b0}}, r_nxt.pk_max - r_nxt.pk_min}; // R11
            r_nxt.st  = ST_GAIN;
         end
         ST_GAIN:
         begin
            prod = $signed(r_r.val)
                   * $signed({1'b0, r_r.gain[r_r.ctrl[RANGE_LSB +: 2]]}); // R5
            r_nxt.val = prod[GAIN_FRAC +: VAL_W]; // R5
            r_nxt.st  = ST_ZERO;
         end
         ST_ZERO:
         begin
            r_nxt.pre_zero = r_r.val;
            if (r_r.ctrl[ZERO_EN_BIT])
               r_nxt.val = r_r.val - r_r.zero_ref; // R6
            if (units == UNITS_AMPS)
               r_nxt.st = ST_PUSH; // R9
            else
            begin
               r_nxt = div_start(r_nxt,
                  {{(DIV_W-VAL_W-RESP_FRAC){r_nxt.val[VAL_W-1]}}, r_nxt.val, 12'h000},
                  {16'h0, resp}); // R7
               r_nxt.st = ST_DIVR;
            end
         end
         ST_DIVR:
         begin
            if (r_r.dcnt == 6'h0)
            begin
               r_nxt.val = div_result(r_r); // R7
               if (units == UNITS_WCM2)
               begin
                  r_nxt = div_start(r_nxt,
                     {{(DIV_W-VAL_W-AREA_FRAC){r_nxt.val[VAL_W-1]}}, r_nxt.val, 8'h00},
                     {16'h0, r_r.area}); // R10
                  r_nxt.st = ST_DIVA;
               end
               else
                  r_nxt.st = ST_PUSH; // R9
            end
         end
         ST_DIVA:
         begin
            if (r_r.dcnt == 6'h0)
            begin
               r_nxt.val = div_result(r_r); // R10
               r_nxt.st  = ST_PUSH;
            end
         end
         ST_PUSH:
         begin
            if (buf_ready)
            begin
               r_nxt.last = r_r.val; // R13
               r_nxt.st   = ST_IDLE;
            end
         end
         default: r_nxt.st = ST_IDLE;
      endcase

      // a units, range, mode or length change restarts the filter history
      if (clr)
      begin
         r_nxt.sum   = '0; // R3
         r_nxt.cnt   = '0; // R3
         r_nxt.ptr   = '0;
         r_nxt.pk_ok = 1'b0;
      end
      r_nxt.in_rdy = (r_nxt.st == ST_IDLE);
   end

   // state register with reset values
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         r_r           <= '0; // R3
         r_r.st        <= ST_IDLE;
         r_r.in_rdy    <= 1'b1;
         r_r.ctrl      <= CTRL_RST;
         r_r.zero_ref  <= ZERO_RST;
         r_r.user_resp <= RESP_RST;
         r_r.area      <= AREA_RST;
         r_r.gain      <= {4{GAIN_RST}};
         r_r.resp_off  <= {TBL_N{RESP_RST}};
         r_r.resp_on   <= {TBL_N{RESP_RST}};
      end
      else
         r_r <= r_nxt;
   end

   // sample history ring for the moving average
   always_ff @(posedge sys_clk)
   begin
      if (r_r.st == ST_ACC)
         hist[r_r.ptr] <= r_r.smp; // R1
      hist_old_r <= hist[r_r.ptr];
   end

   result_skid_buffer #(
      .W (VAL_W)
   ) u_out_buf (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .in_valid  (r_r.st == ST_PUSH),
      .in_data   (r_r.val),
      .in_ready  (buf_ready),
      .out_valid (res_valid),
      .out_data  (res_data),
      .out_ready (res_ready)
   );

   assign reg_rdata = r_r.rdata;
   assign smp_ready = r_r.in_rdy;

endmodule

// file: meter_chain_properties.sv
// port assertions for the meter sample processing chain
`timescale 1ns/1ps
module meter_chain_properties
   import meter_chain_pkg::*;
(
   input wire logic                sys_clk,
   input wire logic                sys_rst,
   input wire logic [ADDR_W-1:0]   reg_addr,
   input wire logic [DATA_W-1:0]   reg_wdata,
   input wire logic                reg_wr,
   input wire logic                reg_rd,
   input wire logic [DATA_W-1:0]   reg_rdata,
   input wire logic                smp_valid,
   input wire logic [SAMPLE_W-1:0] smp_data,
   input wire logic                smp_ready,
   input wire logic                res_valid,
   input wire logic [VAL_W-1:0]    res_data,
   input wire logic                res_ready
);
   typedef struct packed {
      logic [CTRL_W-1:0] ctrl;
      logic [3:0]        pend;
   } mon_s;
   mon_s mon_r;
   mon_s mon_nxt;
   logic fast;
   logic peak;

   // shadow control word, count of results still owed
   always_comb
   begin
      mon_nxt = mon_r;
      if (reg_wr && reg_addr == CTRL_OFS)
         mon_nxt.ctrl = reg_wdata[CTRL_W-1:0];
      mon_nxt.pend = mon_r.pend + 4'(smp_valid && smp_ready) - 4'(res_valid && res_ready);
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         mon_r <= '{ctrl: CTRL_RST, pend: 4'h0};
      else
         mon_r <= mon_nxt;
   end

   // shortest path: no averaging, amps, not peak mode
   assign fast = !mon_r.ctrl[AVG_EN_BIT] && mon_r.ctrl[UNITS_LSB+:3] == UNITS_AMPS
                 && mon_r.ctrl[MODE_LSB+:2] != MODE_PEAK;
   assign peak = mon_r.ctrl[MODE_LSB+:2] == MODE_PEAK;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   sequence take_s;
      smp_valid && smp_ready;
   endsequence
   sequence busy_s;
      !smp_ready [*3];
   endsequence

   reset_out_a: assert property (disable iff (1'b0)
      sys_rst |=> !res_valid && smp_ready && reg_rdata == '0)
      else $error("outputs not idle after reset");
   read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
      else $error("read data outside its cycle");
   ctrl_back_a: assert property (reg_rd && reg_addr == CTRL_OFS
      |=> reg_rdata == DATA_W'(mon_r.ctrl))
      else $error("control readback wrong");
   take_busy_a: assert property (take_s |=> !smp_ready)
      else $error("second sample accepted in flight");
   fast_path_a: assert property (fast && !res_valid ##0 take_s
      |=> busy_s ##1 res_valid && smp_ready)
      else $error("short path latency wrong");
   result_hold_a: assert property (res_valid && !res_ready |=> res_valid && $stable(res_data))
      else $error("stalled result changed");
   result_owed_a: assert property (res_valid |-> mon_r.pend != 4'h0)
      else $error("result without a sample");
   peak_sign_a: assert property (peak && res_valid |-> !res_data[VAL_W-1])
      else $error("negative peak-to-peak");
endmodule

bind meter_sample_chain meter_chain_properties meter_chain_properties_inst (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .smp_valid(smp_valid),
   .smp_data(smp_data), .smp_ready(smp_ready), .res_valid(res_valid),
   .res_data(res_data), .res_ready(res_ready)
);

// file: adc_sample_source.sv
// converter model: offers one sample, held until taken or until 300 cycles pass
`timescale 1ns/1ps
module adc_sample_source
   import meter_chain_pkg::*;
(
   input  wire logic           sys_clk,
   input  wire logic           smp_ready,
   output logic                smp_valid,
   output logic [SAMPLE_W-1:0] smp_data
);
   // nothing offered at start
   initial
   begin
      smp_valid = 1'b0;
      smp_data  = '0;
   end

   // offer after gap cycles, give up after a bounded wait
   task automatic send(input logic [SAMPLE_W-1:0] v, input int gap, output bit ok);
      int n;
      n = 0;
      repeat (gap) @(posedge sys_clk);
      smp_valid <= 1'b1;
      smp_data  <= v;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (smp_ready !== 1'b1 && n < 300);
      ok = (smp_ready === 1'b1);
      smp_valid <= 1'b0;
      smp_data  <= ~v; // stale line, not the last value
   endtask
endmodule

// file: meter_sample_chain_test.sv
// self-checking bench for the meter sample processing chain
`timescale 1ns/1ps
module meter_sample_chain_test
   import meter_chain_pkg::*;
;
   logic                sys_clk;
   logic                sys_rst;
   logic [ADDR_W-1:0]   reg_addr;
   logic [DATA_W-1:0]   reg_wdata;
   logic                reg_wr;
   logic                reg_rd;
   logic [DATA_W-1:0]   reg_rdata;
   logic                smp_valid;
   logic [SAMPLE_W-1:0] smp_data;
   logic                smp_ready;
   logic                res_valid;
   logic [VAL_W-1:0]    res_data;
   logic                res_ready;
   int                  n_mismatch;
   int                  cmp_count;
   bit                  ok;
   logic [ADDR_W-1:0]   ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20, 8'h40, 8'hfc};
   logic [DATA_W-1:0]   re [8] = '{32'h0, 32'h0, 32'h0, 32'h1000, 32'h100, 32'h100,
                                   32'h1000, 32'h0};
   logic [DATA_W-1:0]   cv [7] = '{32'h0, 32'h40, 32'h50, 32'h1040, 32'h1060, 32'h10c0,
                                   32'h40};
   logic [VAL_W-1:0]    ev [7] = '{32'hc8, 32'h64, 32'h190, 32'h32, 32'h19, 32'h32,
                                   32'h320};

   meter_sample_chain meter_sample_chain_inst (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .smp_valid(smp_valid),
      .smp_data(smp_data), .smp_ready(smp_ready), .res_valid(res_valid),
      .res_data(res_data), .res_ready(res_ready));
   adc_sample_source adc_sample_source_inst (
      .sys_clk(sys_clk), .smp_ready(smp_ready), .smp_valid(smp_valid), .smp_data(smp_data));

   // 25 MHz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic end_sim();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t seen %h want %h", $time, seen, exp);
      end
   endtask

   // register bus: one-cycle strobes, read data in the next cycle
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(posedge sys_clk);
      chk(reg_rdata, e);
   endtask

   // take one result, bounded wait
   task automatic get_res(input logic [VAL_W-1:0] exp);
      int n;
      logic [VAL_W-1:0] got;
      n = 0;
      res_ready <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (res_valid !== 1'b1 && n < 400);
      got = res_data;
      res_ready <= 1'b0;
      if (res_valid !== 1'b1)
      begin
         n_mismatch++;
         end_sim();
      end
      @(posedge sys_clk);
      chk(got, exp);
   endtask

   task automatic run(input logic [SAMPLE_W-1:0] s, input logic [VAL_W-1:0] exp);
      adc_sample_source_inst.send(s, 2, ok);
      if (!ok)
      begin
         n_mismatch++;
         end_sim();
      end
      get_res(exp);
   endtask

   initial
   begin
      n_mismatch = 0;
      cmp_count  = 0;
      sys_rst    = 1'b1;
      reg_addr   = '0;
      reg_wdata  = '0;
      reg_wr     = 1'b0;
      reg_rd     = 1'b0;
      res_ready  = 1'b0;
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      // reset values, command and unmapped places
      foreach (ra[i])
         rdchk(ra[i], re[i]);
      wr(CTRL_OFS, 32'hffff_ffff);
      rdchk(CTRL_OFS, 32'h1fff);
      wr(CTRL_OFS, 32'h0);
      $display("test registers done");
      // gain per range
      run(24'h000064, 32'h64);
      wr(8'h20, 32'h200);
      run(24'hfffff9, 32'hffff_fff2);
      wr(8'h24, 32'h300);
      wr(CTRL_OFS, 32'h100);
      run(24'h000005, 32'hf);
      wr(8'h20, 32'h100);
      $display("test gain done");
      // zero reference loaded, captured, disabled
      wr(ZERO_OFS, 32'ha);
      wr(CTRL_OFS, 32'h8);
      run(24'h32, 32'h28);
      wr(CMD_OFS, 32'h1);
      rdchk(ZERO_OFS, 32'h32);
      run(24'h46, 32'h14);
      wr(CTRL_OFS, 32'h0);
      run(24'h46, 32'h46);
      $display("test zero done");
      // every length, partial mean, window slide, clears
      for (int i = 3; i >= 0; i--)
      begin
         wr(CTRL_OFS, 32'((i << 1) | 1));
         run(24'h3c, 32'h3c);
      end
      run(24'h14, 32'h28);
      rdchk(STATUS_OFS, 32'h2);
      wr(CTRL_OFS, 32'h101);
      repeat (10) run(24'h14, 32'h3c);
      run(24'h82, 32'h5d);
      wr(CTRL_OFS, 32'h501);
      run(24'h0a, 32'h1e);
      repeat (200) @(posedge sys_clk);
      run(24'h14, 32'h2d);
      wr(CTRL_OFS, 32'h541);
      run(24'h0a, 32'h1e);
      $display("test averaging done");
      // responsivity tables, user value, units
      wr(8'h40, 32'h2000);
      wr(8'h80, 32'h800);
      wr(8'h44, 32'h400);
      wr(USER_RESP_OFS, 32'h4000);
      wr(AREA_OFS, 32'h200);
      foreach (cv[i])
      begin
         wr(WAVE_OFS, 32'(i == 6));
         wr(CTRL_OFS, cv[i]);
         run(24'hc8, ev[i]);
      end
      $display("test units done");
      // peak-to-peak
      wr(CTRL_OFS, 32'h800);
      run(24'h1e, 32'h0);
      run(24'h50, 32'h32);
      run(24'h0a, 32'h46);
      rdchk(RESULT_OFS, 32'h46);
      $display("test peak done");
      // receiver stalls: buffer fills, fourth sample refused
      wr(CTRL_OFS, 32'h0);
      for (int i = 1; i <= 4; i++)
      begin
         adc_sample_source_inst.send(24'(i), 1, ok);
         chk(32'(ok), 32'(i < 4));
      end
      for (int i = 1; i <= 3; i++)
         get_res(32'(i));
      run(24'h5, 32'h5);
      $display("test buffer done");
      end_sim();
   end
endmodule
